// [mpsm_defs.svh]
`ifndef MPSM_DEFS_SVH
`define MPSM_DEFS_SVH
`define MPSM_CLK_HZ 20000000
`define MPSM_FAST_BPS 30000000
`define MPSM_SLOW_BPS 2000000
`define MPSM_SLOW_MIN_HALF ((`MPSM_CLK_HZ + 2 * `MPSM_SLOW_BPS - 1) / (2 * `MPSM_SLOW_BPS))
`define MPSM_FAST_MIN_HALF 1
`define MPSM_DIV_RST 8'h05
`define MPSM_PORTS 8
`define MPSM_AUX_PINS 3
`define MPSM_CPOL_BIT 1
`define MPSM_CPHA_BIT 0
`endif

// [mpsm_pkg.sv]
package mpsm_pkg;
   typedef enum logic [1:0] {
      MPSM_IDLE = 2'b00,
      MPSM_LOAD = 2'b01,
      MPSM_SHIFT = 2'b11,
      MPSM_DONE = 2'b10
   } mpsm_state_t;
endpackage : mpsm_pkg

// [mpsm_fifo.sv]
`timescale 1ns/1ps
module mpsm_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW:0] wr;
      logic [AW:0] rd;
   } mpsm_fifo_st_t;
   mpsm_fifo_st_t s_q, s_d;
   logic [WIDTH-1:0] mem [DEPTH];
   logic full, empty;
   assign empty = s_q.wr == s_q.rd;
   assign full = (s_q.wr[AW] != s_q.rd[AW]) && (s_q.wr[AW-1:0] == s_q.rd[AW-1:0]);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem[s_q.rd[AW-1:0]];
   always_comb begin
      s_d = s_q;
      if (in_valid && !full) s_d.wr = s_q.wr + 1'b1;
      if (out_ready && !empty) s_d.rd = s_q.rd + 1'b1;
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
         if (in_valid && !full) mem[s_q.wr[AW-1:0]] <= in_data;
      end
   end
endmodule : mpsm_fifo

// [mpsm_top.sv]
`timescale 1ns/1ps
`include "mpsm_defs.svh"
// Contract
// - Serial pins released unless programming is active
// - Eight ports share clock and data pins
// - Only one port select asserted at once
// - All four clock modes, chosen per transfer
// - Modes 0 and 2 run up to fastest; code clamps to slow rate when the previous transfer was mode 1 or 3
// - Modes 1 and 3 limited to slow rate; code clamps only when the previous transfer was mode 1 or 3
// - Serial clock rate set by user divider
// - Test engine supports two and four wire; two wire drives serial_io_o throughout and reads serial_in_i
// - Reduced test classes via two wire form
// - Three general purpose pins provided
// - Software drives one pin as target reset
module mpsm_top #(
   parameter int PORTS = `MPSM_PORTS,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [7:0] tx_data,
   input wire logic tx_last,
   output logic rx_valid,
   output logic [7:0] rx_data,
   input wire logic spi_start,
   input wire logic [2:0] spi_port,
   input wire logic [1:0] spi_mode,
   input wire logic spi_lsb_first,
   input wire logic [7:0] clk_div,
   input wire logic test_mode,
   input wire logic two_wire,
   output logic busy,
   output logic serial_clk_o,
   output logic serial_clk_oe_n,
   output logic serial_out_o,
   output logic serial_out_oe_n,
   input wire logic serial_in_i,
   output logic serial_io_o,
   output logic serial_io_oe_n,
   output logic [PORTS-1:0] port_select_n_o,
   output logic [PORTS-1:0] port_select_oe_n,
   input wire logic [2:0] aux_out,
   input wire logic [2:0] aux_drive,
   input wire logic core_reset_req,
   output logic [2:0] aux_pin_o,
   output logic [2:0] aux_pin_oe_n,
   input wire logic [2:0] aux_pin_i,
   output logic [2:0] aux_in
);
   typedef struct packed {
      mpsm_pkg::mpsm_state_t st;
      logic [7:0] div;
      logic [7:0] cnt;
      logic [7:0] sh;
      logic [7:0] rxs;
      logic [3:0] bits;
      logic [2:0] port;
      logic [1:0] mode;
      logic lsb;
      logic last;
      logic tst;
      logic two;
      logic sclk;
      logic rxv;
      logic [7:0] rxd;
      logic [1:0] in_s1;
      logic [1:0] in_s2;
      logic [2:0] aux_s1;
      logic [2:0] aux_s2;
      logic [2:0] aux_po;
      logic [2:0] aux_poe_n;
      logic [PORTS-1:0] sel_n;
   } mpsm_st_t;
   mpsm_st_t s_q, s_d;
   logic f_valid, f_ready, f_last;
   logic [7:0] f_data;
   logic in_bit, half_end, act;
   logic [7:0] min_half, div_use;
   mpsm_fifo #(.WIDTH(9), .DEPTH(DEPTH)) u_fifo (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .in_valid(tx_valid),
      .in_ready(tx_ready),
      .in_data({tx_last, tx_data}),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data({f_last, f_data})
   );
   assign act = s_q.st != mpsm_pkg::MPSM_IDLE;
   assign f_ready = s_q.st == mpsm_pkg::MPSM_LOAD;
   assign in_bit = s_q.two ? s_q.in_s2[1] : s_q.in_s2[0];
   assign min_half = s_q.mode[`MPSM_CPHA_BIT] ? 8'(`MPSM_SLOW_MIN_HALF) : 8'(`MPSM_FAST_MIN_HALF);
   assign div_use = (clk_div < min_half) ? min_half : clk_div;
   assign half_end = s_q.cnt + 8'h01 >= s_q.div;
   always_comb begin
      s_d = s_q;
      s_d.rxv = 1'b0;
      s_d.in_s1 = {serial_io_i_sample(), serial_in_i};
      s_d.in_s2 = s_q.in_s1;
      s_d.aux_s1 = aux_pin_i;
      s_d.aux_s2 = s_q.aux_s1;
      s_d.aux_po = aux_out;
      s_d.aux_po[0] = aux_out[0] | core_reset_req;
      s_d.aux_poe_n = ~(aux_drive | {2'b00, core_reset_req});
      case (s_q.st)
         mpsm_pkg::MPSM_IDLE: begin
            s_d.sel_n = '1;
            if (spi_start && f_valid) begin
               s_d.port = spi_port;
               s_d.mode = test_mode ? 2'b00 : spi_mode;
               s_d.lsb = spi_lsb_first;
               s_d.tst = test_mode;
               s_d.two = test_mode & two_wire;
               s_d.div = div_use;
               s_d.sclk = test_mode ? 1'b0 : spi_mode[`MPSM_CPOL_BIT];
               s_d.st = mpsm_pkg::MPSM_LOAD;
            end
         end
         mpsm_pkg::MPSM_LOAD: begin
            s_d.sh = f_data;
            s_d.last = f_last;
            s_d.bits = 4'h0;
            s_d.cnt = 8'h00;
            if (!s_q.tst) begin
               s_d.sel_n = '1;
               s_d.sel_n[s_q.port] = 1'b0;
            end
            s_d.st = mpsm_pkg::MPSM_SHIFT;
         end
         mpsm_pkg::MPSM_SHIFT: begin
            s_d.cnt = s_q.cnt + 8'h01;
            if (half_end) begin
               s_d.cnt = 8'h00;
               s_d.sclk = ~s_q.sclk;
               if (s_q.sclk == s_q.mode[`MPSM_CPOL_BIT]) begin
                  if (!s_q.mode[`MPSM_CPHA_BIT])
                     s_d.rxs = s_q.lsb ? {in_bit, s_q.rxs[7:1]} : {s_q.rxs[6:0], in_bit};
                  else if (s_q.bits != 4'h0)
                     s_d.sh = s_q.lsb ? {1'b0, s_q.sh[7:1]} : {s_q.sh[6:0], 1'b0};
               end else begin
                  if (s_q.mode[`MPSM_CPHA_BIT])
                     s_d.rxs = s_q.lsb ? {in_bit, s_q.rxs[7:1]} : {s_q.rxs[6:0], in_bit};
                  else
                     s_d.sh = s_q.lsb ? {1'b0, s_q.sh[7:1]} : {s_q.sh[6:0], 1'b0};
                  s_d.bits = s_q.bits + 4'h1;
                  if (s_q.bits == 4'h7) s_d.st = mpsm_pkg::MPSM_DONE;
               end
            end
         end
         mpsm_pkg::MPSM_DONE: begin
            s_d.rxv = 1'b1;
            s_d.rxd = s_q.rxs;
            if (!s_q.last && f_valid) begin
               s_d.st = mpsm_pkg::MPSM_LOAD;
            end else if (s_q.last) begin
               s_d.sel_n = '1;
               s_d.st = mpsm_pkg::MPSM_IDLE;
            end else begin
               s_d.rxv = 1'b0;
            end
         end
         default: s_d.st = mpsm_pkg::MPSM_IDLE;
      endcase
   end
   function automatic logic serial_io_i_sample();
      return serial_in_i;
   endfunction : serial_io_i_sample
   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '0;
         s_q.sel_n <= '1;
         s_q.aux_poe_n <= '1;
         s_q.div <= `MPSM_DIV_RST;
      end else if (ce) begin
         s_q <= s_d;
      end
   end
   logic [7:0] out_bit_src;
   assign out_bit_src = s_q.sh;
   always_ff @(posedge clk) begin
      if (rst) begin
         serial_clk_o <= 1'b0;
         serial_clk_oe_n <= 1'b1;
         serial_out_o <= 1'b0;
         serial_out_oe_n <= 1'b1;
         serial_io_o <= 1'b0;
         serial_io_oe_n <= 1'b1;
         port_select_n_o <= '1;
         port_select_oe_n <= '1;
         busy <= 1'b0;
         rx_valid <= 1'b0;
         rx_data <= 8'h00;
         aux_pin_o <= 3'h0;
         aux_pin_oe_n <= 3'h7;
         aux_in <= 3'h0;
      end else if (ce) begin
         serial_clk_o <= s_q.sclk;
         serial_clk_oe_n <= !act;
         serial_out_o <= s_q.lsb ? out_bit_src[0] : out_bit_src[7];
         serial_out_oe_n <= !act || s_q.two;
         serial_io_o <= s_q.lsb ? out_bit_src[0] : out_bit_src[7];
         serial_io_oe_n <= !(act && s_q.two);
         port_select_n_o <= s_q.sel_n;
         port_select_oe_n <= act ? '0 : '1;
         busy <= act;
         rx_valid <= s_q.rxv;
         rx_data <= s_q.rxd;
         aux_pin_o <= s_q.aux_po;
         aux_pin_oe_n <= s_q.aux_poe_n;
         aux_in <= s_q.aux_s2;
      end
   end
endmodule : mpsm_top

// [mpsm_checker.sv]
`timescale 1ns/1ps
module mpsm_checker #(
   parameter int PORTS = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic busy,
   input wire logic serial_clk_o,
   input wire logic serial_clk_oe_n,
   input wire logic serial_out_oe_n,
   input wire logic serial_io_oe_n,
   input wire logic [PORTS-1:0] port_select_n_o,
   input wire logic [PORTS-1:0] port_select_oe_n,
   input wire logic [1:0] spi_mode,
   input wire logic core_reset_req,
   input wire logic [2:0] aux_pin_o,
   input wire logic [2:0] aux_pin_oe_n,
   input wire logic [2:0] aux_drive
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_idle;
      !busy [*2];
   endsequence
   sequence s_slow_edge;
      busy && spi_mode[0] && $changed(serial_clk_o);
   endsequence
   property p_rel;
      s_idle |-> serial_clk_oe_n && serial_out_oe_n && serial_io_oe_n && &port_select_oe_n;
   endproperty
   a_rel: assert property (p_rel) else $error("pins driven while idle");
   property p_one;
      $onehot0(~port_select_n_o & ~port_select_oe_n);
   endproperty
   a_one: assert property (p_one) else $error("two selects");
   property p_clk;
      !serial_clk_oe_n |-> busy || $past(busy);
   endproperty
   a_clk: assert property (p_clk) else $error("clock driven idle");
   property p_io;
      !serial_io_oe_n |-> busy || $past(busy);
   endproperty
   a_io: assert property (p_io) else $error("io driven idle");
   property p_sel;
      $rose(|(~port_select_n_o & ~port_select_oe_n)) |-> busy;
   endproperty
   a_sel: assert property (p_sel) else $error("select outside transfer");
   property p_slow;
      s_slow_edge |=> $stable(serial_clk_o) [*4];
   endproperty
   a_slow: assert property (p_slow) else $error("slow mode too fast");
   property p_rst;
      core_reset_req [*3] |-> !aux_pin_oe_n[0] && aux_pin_o[0];
   endproperty
   a_rst: assert property (p_rst) else $error("core reset not driven");
   property p_aux;
      !aux_drive[2] [*3] |-> aux_pin_oe_n[2];
   endproperty
   a_aux: assert property (p_aux) else $error("aux pin driven");
endmodule : mpsm_checker
bind mpsm_top mpsm_checker #(.PORTS(PORTS)) u_chk (.clk, .rst, .busy, .serial_clk_o,
   .serial_clk_oe_n, .serial_out_oe_n, .serial_io_oe_n, .port_select_n_o,
   .port_select_oe_n, .spi_mode, .core_reset_req, .aux_pin_o, .aux_pin_oe_n, .aux_drive);

// [mpsm_spi_peer.sv]
`timescale 1ns/1ps
module mpsm_spi_peer #(
   parameter logic [7:0] RESP = 8'hC5
) (
   input wire logic sclk,
   input wire logic sel_n,
   input wire logic cpha,
   input wire logic mosi,
   output logic miso
);
   logic [2:0] idx = 3'h7;
   logic lead = 1'b1;
   logic [7:0] rxd = 8'h00;
   initial miso = 1'b0;
   // Released line shows the inverse of the last bit
   always @(posedge sel_n) miso = ~miso;
   always @(negedge sel_n) begin
      lead = 1'b1;
      idx = cpha ? 3'h7 : 3'h6;
      if (!cpha) miso = RESP[7];
   end
   // Shift on one edge of each pair, capture on the other
   always @(sclk) begin
      if (sel_n === 1'b0) begin
         if (lead == cpha) begin
            miso = RESP[idx];
            idx = idx - 3'h1;
         end else begin
            rxd = {rxd[6:0], mosi};
         end
         lead = ~lead;
      end
   end
endmodule : mpsm_spi_peer

// [mpsm_top_tb_top.sv]
`timescale 1ns/1ps
module mpsm_top_tb_top;
   logic clk = 1'b0, rst = 1'b1, ce = 1'b1, tx_valid = 1'b0, tx_last = 1'b0, spi_start = 1'b0;
   logic spi_lsb_first = 1'b0, test_mode = 1'b0, two_wire = 1'b0, core_reset_req = 1'b0;
   logic [7:0] tx_data = 8'h00, clk_div = 8'h03;
   logic [2:0] spi_port = 3'h0, aux_out = 3'h0, aux_drive = 3'h0;
   logic [1:0] spi_mode = 2'h0;
   logic tx_ready, rx_valid, busy, serial_clk_o, serial_clk_oe_n, serial_out_o, serial_out_oe_n;
   logic serial_io_o, serial_io_oe_n, serial_in_i, miso;
   logic [7:0] rx_data, port_select_n_o, port_select_oe_n;
   logic [2:0] aux_pin_o, aux_pin_oe_n, aux_pin_i, aux_in;
   int failures = 0, n_checks = 0;
   always #25 clk = ~clk;
   assign serial_in_i = miso;
   assign aux_pin_i = aux_pin_o | aux_pin_oe_n;
   mpsm_top #(.PORTS(8), .DEPTH(8)) DUT (.*);
   mpsm_spi_peer peer (.sclk(serial_clk_o), .sel_n(&(port_select_n_o | port_select_oe_n)),
      .cpha(spi_mode[0]), .mosi(serial_out_o), .miso(miso));
   task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic xfer(input logic [2:0] p, input logic js);
      logic [7:0] d;
      int n;
      @(negedge clk);
      spi_port = p;
      spi_mode = p[1:0];
      spi_lsb_first = p[2];
      // Half period must exceed the input synchroniser latency
      clk_div = 8'h06 + {5'h00, p};
      test_mode = js;
      two_wire = js;
      tx_valid = 1'b1;
      tx_data = 8'h3C + {5'h00, p};
      @(negedge clk);
      tx_data = ~tx_data;
      tx_last = 1'b1;
      @(negedge clk);
      tx_valid = 1'b0;
      tx_last = 1'b0;
      spi_start = 1'b1;
      @(negedge clk);
      spi_start = 1'b0;
      for (int b = 0; b < 2; b++) begin
         for (n = 0; n < 600 && rx_valid !== 1'b1; n++) @(negedge clk);
         chk("rxv", {7'h00, rx_valid}, 8'h01);
         if (!js) chk("rx", rx_data, p[2] ? 8'hA3 : 8'hC5);
         if (b == 0) chk("sel", port_select_n_o | port_select_oe_n, js ? 8'hFF : ~(8'h01 << p));
         @(negedge clk);
      end
      d = ~(8'h3C + {5'h00, p});
      if (p[2]) d = {<<{d}};
      if (!js) chk("mosi", peer.rxd, d);
      for (n = 0; n < 60 && busy !== 1'b0; n++) @(negedge clk);
      repeat (2) @(negedge clk);
      chk("busy", {7'h00, busy}, 8'h00);
      chk("rel", {4'h0, serial_clk_oe_n, serial_out_oe_n, serial_io_oe_n, &port_select_oe_n}, 8'h0F);
   endtask : xfer
   task automatic aux_chk;
      @(negedge clk);
      aux_out = 3'h4;
      aux_drive = 3'h5;
      repeat (6) @(negedge clk);
      chk("aux", {5'h00, aux_in}, 8'h06);
      core_reset_req = 1'b1;
      repeat (6) @(negedge clk);
      chk("corerst", {4'h0, aux_in, aux_pin_o[0]}, 8'h0F);
   endtask : aux_chk
   task automatic tally_and_finish;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (3) @(negedge clk);
      rst = 1'b0;
      for (int p = 0; p < 8; p++) xfer(3'(p), 1'b0);
      xfer(3'h0, 1'b1);
      aux_chk();
      tally_and_finish();
   end
   initial begin
      #2000000;
      failures++;
      tally_and_finish();
   end
endmodule : mpsm_top_tb_top
